// ### verilog/fps_flash_end.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module fps_flash_end #(
   parameter logic [7:0] MAKER_CODE = 8'hA5, // value arbitrary
   parameter logic [15:0] DEVICE_CODE = 16'h1234, // value arbitrary
   parameter logic [63:0] UNIQUE_NUMBER = 64'h0123456789ABCDEF // value arbitrary
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clkEn,
   fps_link_if.dev link,
   input wire logic cfgWrEn,
   input wire logic [1:0] cfgSel,
   input wire logic [7:0] cfgWrData,
   input wire logic [7:0] status1,
   input wire logic [7:0] status2,
   input wire logic opBusy,
   input wire logic paramWrEn,
   input wire logic [7:0] paramWrAddr,
   input wire logic [7:0] paramWrData,
   output logic [7:0] config1,
   output logic [7:0] config2,
   output logic [7:0] config3
);
   import fps_pkg::*;

   logic [2:0] csSync_reg;
   logic [2:0] sckSync_reg;
   logic [3:0] laneMeta_reg;
   logic [3:0] lane_reg;
   logic [7:0] cfg1_reg;
   logic [7:0] cfg2_reg;
   logic [7:0] cfg3_reg;
   logic [7:0] paramMem [PARAM_DEPTH];
   fps_dev_state_type state_reg;
   fps_src_type src_reg;
   logic [5:0] cyc_reg;
   logic [5:0] dumTgt_reg;
   logic [7:0] opSh_reg;
   logic [31:0] addrSh_reg;
   logic [7:0] startIdx_reg;
   logic wide_reg;
   logic [7:0] byteCnt_reg;
   logic [2:0] outCnt_reg;
   logic [7:0] outSh_reg;
   logic [3:0] laneOut_reg;
   logic [3:0] laneOe_reg;
   logic csHigh, sckRise, sckFall, quadPeriph, quadMode;
   logic [5:0] cycNext, opCyc, addrCyc;
   logic [7:0] opNext;
   logic [31:0] addrNext;
   logic [7:0] byteNow, curByte;
   logic [2:0] uidSel;

   ////////////////////////////////////////////////////////////////////////
   // link inputs: [0] and laneMeta_reg are the metastable stages, sckSync_reg[2] feeds edge finding, csSync_reg[2] is unused
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         csSync_reg <= 3'h7;
         sckSync_reg <= 3'h0;
         laneMeta_reg <= 4'hF;
         lane_reg <= 4'hF;
      end else if (clkEn) begin
         csSync_reg <= {csSync_reg[1:0], link.csN};
         sckSync_reg <= {sckSync_reg[1:0], link.sck};
         laneMeta_reg <= link.lanes;
         lane_reg <= laneMeta_reg;
      end
   end

   assign csHigh = csSync_reg[1];
   assign sckRise = sckSync_reg[1] & ~sckSync_reg[2];
   assign sckFall = ~sckSync_reg[1] & sckSync_reg[2];

   ////////////////////////////////////////////////////////////////////////
   // volatile configuration; the load port stands in for the write commands
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cfg1_reg <= CFG1_RESET;
         cfg2_reg <= CFG2_RESET;
         cfg3_reg <= CFG3_RESET;
      end else if (clkEn && cfgWrEn) begin
         if (cfgSel == CFG_SEL_1) begin
            cfg1_reg <= cfgWrData;
         end
         if (cfgSel == CFG_SEL_2) begin
            cfg2_reg <= cfgWrData;
         end
         if (cfgSel == CFG_SEL_3) begin
            cfg3_reg <= cfgWrData;
         end
      end
   end

   assign config1 = cfg1_reg;
   assign config2 = cfg2_reg;
   assign config3 = cfg3_reg;
   assign quadPeriph = cfg2_reg[CFG2_QPI_BIT];
   assign quadMode = cfg1_reg[CFG1_QUAD_BIT];

   always_ff @(posedge mclk) begin
      if (clkEn && paramWrEn) begin
         paramMem[paramWrAddr] <= paramWrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command decode, sampled on the rising clock edge
   assign cycNext = cyc_reg + 6'h01;
   assign opCyc = quadPeriph ? OPCODE_CYC_QUAD : OPCODE_CYC_SINGLE;
   assign addrCyc = cfg2_reg[CFG2_ADDR4_BIT] ? ADDR_BITS_LONG : ADDR_BITS_SHORT;
   assign opNext = quadPeriph ? {opSh_reg[3:0], lane_reg} : {opSh_reg[6:0], lane_reg[0]};
   assign addrNext = quadPeriph ? {addrSh_reg[27:0], lane_reg} : {addrSh_reg[30:0], lane_reg[0]};

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_reg <= DS_OPCODE;
         src_reg <= SRC_ID;
         cyc_reg <= 6'h00;
         dumTgt_reg <= 6'h00;
         opSh_reg <= 8'h00;
         addrSh_reg <= 32'h0;
         startIdx_reg <= 8'h00;
         wide_reg <= 1'b0;
      end else if (clkEn) begin
         if (csHigh) begin
            state_reg <= DS_OPCODE;
            cyc_reg <= 6'h00;
         end else if (sckRise) begin
            unique case (state_reg)
               DS_OPCODE: begin
                  opSh_reg <= opNext;
                  cyc_reg <= cycNext;
                  wide_reg <= quadPeriph;
                  startIdx_reg <= 8'h00;
                  if (cycNext == opCyc) begin
                     cyc_reg <= 6'h00;
                     state_reg <= DS_OUT;
                     unique case (opNext)
                        OP_QUAD_IDENT: begin
                           src_reg <= SRC_ID;
                           wide_reg <= 1'b1;
                           if (!(quadPeriph || quadMode) || opBusy) begin
                              state_reg <= DS_IGNORE;
                           end
                        end
                        OP_PARAM: begin
                           src_reg <= SRC_PARAM;
                           state_reg <= DS_ADDR;
                        end
                        OP_UNIQUE: begin
                           src_reg <= SRC_UID;
                           dumTgt_reg <= UNIQUE_DUMMY_CYC;
                           state_reg <= DS_DUMMY;
                        end
                        OP_STATUS1: src_reg <= SRC_SR1;
                        OP_STATUS2: src_reg <= SRC_SR2;
                        OP_CONFIG1: src_reg <= SRC_CR1;
                        OP_CONFIG2: src_reg <= SRC_CR2;
                        OP_CONFIG3: src_reg <= SRC_CR3;
                        default: state_reg <= DS_IGNORE;
                     endcase
                     // these reads go through the any-register command in quad-peripheral mode
                     if (quadPeriph && (opNext == OP_STATUS2 || opNext == OP_CONFIG1 ||
                         opNext == OP_CONFIG2 || opNext == OP_CONFIG3)) begin
                        state_reg <= DS_IGNORE;
                     end
                  end
               end
               DS_ADDR: begin
                  addrSh_reg <= addrNext;
                  cyc_reg <= cycNext;
                  if ((quadPeriph ? {cycNext[3:0], 2'b00} : cycNext) == addrCyc) begin
                     cyc_reg <= 6'h00;
                     startIdx_reg <= addrNext[7:0];
                     dumTgt_reg <= {2'b00, cfg3_reg[CFG3_LAT_MSB:CFG3_LAT_LSB]};
                     state_reg <= (cfg3_reg[CFG3_LAT_MSB:CFG3_LAT_LSB] == 4'h0) ? DS_OUT : DS_DUMMY;
                  end
               end
               DS_DUMMY: begin
                  // lane values are never looked at here
                  cyc_reg <= cycNext;
                  if (cycNext == dumTgt_reg) begin
                     cyc_reg <= 6'h00;
                     state_reg <= DS_OUT;
                  end
               end
               DS_OUT: state_reg <= DS_OUT;
               DS_IGNORE: state_reg <= DS_IGNORE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output byte source; status values are taken live at each byte start
   assign uidSel = 3'h7 - byteCnt_reg[2:0];

   always_comb begin
      byteNow = 8'h00;
      unique case (src_reg)
         SRC_ID: begin
            if (byteCnt_reg == 8'h00) begin
               byteNow = MAKER_CODE;
            end else if (byteCnt_reg == 8'h01) begin
               byteNow = DEVICE_CODE[15:8];
            end else if (byteCnt_reg == 8'h02) begin
               byteNow = DEVICE_CODE[7:0];
            end
         end
         SRC_PARAM: byteNow = paramMem[8'(startIdx_reg + byteCnt_reg)];
         SRC_UID: byteNow = UNIQUE_NUMBER[{uidSel, 3'b000} +: 8];
         SRC_SR1: byteNow = status1;
         SRC_SR2: byteNow = status2;
         SRC_CR1: byteNow = cfg1_reg;
         SRC_CR2: byteNow = cfg2_reg;
         SRC_CR3: byteNow = cfg3_reg;
      endcase
   end

   assign curByte = (outCnt_reg == 3'h0) ? byteNow : outSh_reg;

   // data change on the falling edge so the host samples stable bits on the rise
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         byteCnt_reg <= 8'h00;
         outCnt_reg <= 3'h0;
         outSh_reg <= 8'h00;
         laneOut_reg <= 4'h0;
         laneOe_reg <= 4'h0;
      end else if (clkEn) begin
         if (csHigh || state_reg != DS_OUT) begin
            byteCnt_reg <= 8'h00;
            outCnt_reg <= 3'h0;
            laneOe_reg <= 4'h0;
         end else if (sckFall) begin
            if (wide_reg) begin
               laneOut_reg <= curByte[7:4];
               laneOe_reg <= 4'hF;
               outSh_reg <= {curByte[3:0], 4'h0};
               outCnt_reg <= outCnt_reg + 3'h4;
            end else begin
               laneOut_reg <= {2'b00, curByte[7], 1'b0};
               laneOe_reg <= 4'h2;
               outSh_reg <= {curByte[6:0], 1'b0};
               outCnt_reg <= outCnt_reg + 3'h1;
            end
            if (outCnt_reg == 3'h0) begin
               byteCnt_reg <= byteCnt_reg + 8'h01;
            end
         end
      end
   end

   assign link.devLaneOut = laneOut_reg;
   assign link.devLaneOe = laneOe_reg;
endmodule

// ### shared/fps_pkg.sv
package fps_pkg;
   // instruction codes
   localparam logic [7:0] OP_QUAD_IDENT = 8'hAF;
   localparam logic [7:0] OP_PARAM = 8'h5A;
   localparam logic [7:0] OP_UNIQUE = 8'h4B;
   localparam logic [7:0] OP_STATUS1 = 8'h05;
   localparam logic [7:0] OP_STATUS2 = 8'h07;
   localparam logic [7:0] OP_CONFIG1 = 8'h35;
   localparam logic [7:0] OP_CONFIG2 = 8'h15;
   localparam logic [7:0] OP_CONFIG3 = 8'h33;
   // configuration fields
   localparam int CFG1_QUAD_BIT = 1;
   localparam int CFG2_QPI_BIT = 3;
   localparam int CFG2_ADDR4_BIT = 0;
   localparam int CFG3_LAT_MSB = 3;
   localparam int CFG3_LAT_LSB = 0;
   localparam logic [7:0] CFG1_RESET = 8'h00;
   localparam logic [7:0] CFG2_RESET = 8'h00;
   localparam logic [7:0] CFG3_RESET = 8'h08;
   localparam logic [1:0] CFG_SEL_1 = 2'h0;
   localparam logic [1:0] CFG_SEL_2 = 2'h1;
   localparam logic [1:0] CFG_SEL_3 = 2'h2;
   // cycle, bit and byte counts on the link, and the parameter memory depth
   localparam logic [5:0] OPCODE_CYC_SINGLE = 6'h08;
   localparam logic [5:0] OPCODE_CYC_QUAD = 6'h02;
   localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
   localparam logic [5:0] ADDR_BITS_LONG = 6'h20;
   localparam logic [5:0] UNIQUE_DUMMY_CYC = 6'h20;
   localparam int ID_BYTES = 3;
   localparam int UNIQUE_BYTES = 8;
   localparam int PARAM_DEPTH = 256;
   // timing
   localparam int MCLK_PERIOD_NS = 50;
   localparam int SCK_MAX_SINGLE_MHZ = 133;
   localparam int SCK_MAX_STATUS_QPI_MHZ = 108;
   localparam int SCK_HALF_NS = 400;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int SCK_MHZ = 1000 / (2 * SCK_HALF_CYC * MCLK_PERIOD_NS);

   typedef enum {DS_OPCODE, DS_ADDR, DS_DUMMY, DS_OUT, DS_IGNORE} fps_dev_state_type;
   typedef enum {SRC_ID, SRC_PARAM, SRC_UID, SRC_SR1, SRC_SR2, SRC_CR1, SRC_CR2, SRC_CR3} fps_src_type;
   typedef enum {HS_IDLE, HS_RUN, HS_GAP} fps_host_state_type;
endpackage

// ### shared/fps_link_if.sv
`timescale 1ns/1ps
interface fps_link_if;
   logic csN;
   logic sck;
   logic [3:0] hostLaneOut;
   logic [3:0] hostLaneOe;
   logic [3:0] devLaneOut;
   logic [3:0] devLaneOe;
   logic [3:0] lanes;

   // undriven lanes float high through the board pull-ups
   assign lanes = (devLaneOut & devLaneOe) | (hostLaneOut & hostLaneOe) | ~(devLaneOe | hostLaneOe);

   modport dev (input csN, input sck, input lanes, output devLaneOut, output devLaneOe);
   modport host (output csN, output sck, output hostLaneOut, output hostLaneOe, input lanes);
endinterface

// ### verilog/fps_host_end.sv
`timescale 1ns/1ps
module fps_host_end (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clkEn,
   fps_link_if.host link,
   input wire logic cmdStart,
   input wire logic [7:0] cmdOpcode,
   input wire logic [31:0] cmdAddr,
   input wire logic quadPeriph,
   input wire logic addrFour,
   input wire logic [3:0] latency,
   input wire logic [7:0] byteCount,
   output logic cmdBusy,
   output logic cmdDone,
   output logic [7:0] rxData,
   output logic rxValid
);
   import fps_pkg::*;

   localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);

   fps_host_state_type state_reg;
   logic [3:0] laneMeta_reg;
   logic [3:0] lane_reg;
   logic [3:0] half_reg;
   logic [11:0] cyc_reg;
   logic [11:0] driveEnd_reg, dataStart_reg, total_reg;
   logic wide_reg, dataWide_reg;
   logic [39:0] tx_reg;
   logic [7:0] rxSh_reg;
   logic [2:0] rxCnt_reg;
   logic csN_reg, sck_reg;
   logic [3:0] laneOut_reg, laneOe_reg;
   logic [11:0] instrCyc, addrCyc, dummyCyc, dataCyc;
   logic dw, isParam;
   logic [39:0] txInit, txNext;
   logic [7:0] rxNext;

   always_comb begin
      isParam = (cmdOpcode == OP_PARAM);
      dw = quadPeriph || (cmdOpcode == OP_QUAD_IDENT);
      instrCyc = quadPeriph ? 12'h002 : 12'h008;
      addrCyc = 12'h000;
      dummyCyc = 12'h000;
      txInit = {cmdOpcode, 32'h0};
      if (isParam) begin
         addrCyc = addrFour ? (quadPeriph ? 12'h008 : 12'h020) : (quadPeriph ? 12'h006 : 12'h018);
         dummyCyc = {8'h00, latency};
         txInit = addrFour ? {cmdOpcode, cmdAddr} : {cmdOpcode, cmdAddr[23:0], 8'h00};
      end
      if (cmdOpcode == OP_UNIQUE) begin
         dummyCyc = 12'(UNIQUE_DUMMY_CYC);
      end
      dataCyc = dw ? 12'({byteCount, 1'b0}) : 12'({byteCount, 3'b000});
   end

   assign txNext = wide_reg ? {tx_reg[35:0], 4'h0} : {tx_reg[38:0], 1'b0};
   assign rxNext = dataWide_reg ? {rxSh_reg[3:0], lane_reg} : {rxSh_reg[6:0], lane_reg[1]};

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         laneMeta_reg <= 4'hF;
         lane_reg <= 4'hF;
      end else if (clkEn) begin
         laneMeta_reg <= link.lanes;
         lane_reg <= laneMeta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // the serial clock is mclk divided; SCK_MHZ stays under both limits
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_reg <= HS_IDLE;
         half_reg <= 4'h0;
         cyc_reg <= 12'h000;
         driveEnd_reg <= 12'h000;
         dataStart_reg <= 12'h000;
         total_reg <= 12'h000;
         wide_reg <= 1'b0;
         dataWide_reg <= 1'b0;
         tx_reg <= 40'h0;
         rxSh_reg <= 8'h00;
         rxCnt_reg <= 3'h0;
         csN_reg <= 1'b1;
         sck_reg <= 1'b0;
         laneOut_reg <= 4'h0;
         laneOe_reg <= 4'h0;
         rxData <= 8'h00;
         rxValid <= 1'b0;
         cmdDone <= 1'b0;
      end else if (clkEn) begin
         rxValid <= 1'b0;
         cmdDone <= 1'b0;
         unique case (state_reg)
            HS_IDLE: begin
               if (cmdStart) begin
                  state_reg <= HS_RUN;
                  csN_reg <= 1'b0;
                  half_reg <= 4'h0;
                  cyc_reg <= 12'h000;
                  rxCnt_reg <= 3'h0;
                  wide_reg <= quadPeriph;
                  dataWide_reg <= dw;
                  driveEnd_reg <= instrCyc + addrCyc;
                  dataStart_reg <= instrCyc + addrCyc + dummyCyc;
                  total_reg <= instrCyc + addrCyc + dummyCyc + dataCyc;
                  tx_reg <= txInit;
                  laneOut_reg <= quadPeriph ? txInit[39:36] : {3'b000, txInit[39]};
                  laneOe_reg <= quadPeriph ? 4'hF : 4'h1;
               end
            end
            HS_RUN: begin
               half_reg <= half_reg + 4'h1;
               if (half_reg == HALF_LAST) begin
                  half_reg <= 4'h0;
                  sck_reg <= ~sck_reg;
                  if (!sck_reg) begin
                     if (cyc_reg >= dataStart_reg) begin
                        rxSh_reg <= rxNext;
                        rxCnt_reg <= rxCnt_reg + (dataWide_reg ? 3'h4 : 3'h1);
                        if (rxCnt_reg == (dataWide_reg ? 3'h4 : 3'h7)) begin
                           rxData <= rxNext;
                           rxValid <= 1'b1;
                        end
                     end
                  end else begin
                     cyc_reg <= cyc_reg + 12'h001;
                     tx_reg <= txNext;
                     laneOut_reg <= wide_reg ? txNext[39:36] : {3'b000, txNext[39]};
                     if (cyc_reg + 12'h001 >= driveEnd_reg) begin
                        laneOe_reg <= 4'h0;
                     end
                     if (cyc_reg + 12'h001 == total_reg) begin
                        csN_reg <= 1'b1;
                        cmdDone <= 1'b1;
                        state_reg <= HS_GAP;
                     end
                  end
               end
            end
            HS_GAP: begin
               // deselect must be long enough for the flash to see it
               half_reg <= half_reg + 4'h1;
               if (half_reg == HALF_LAST) begin
                  half_reg <= 4'h0;
                  state_reg <= HS_IDLE;
               end
            end
         endcase
      end
   end

   assign cmdBusy = (state_reg != HS_IDLE);
   assign link.csN = csN_reg;
   assign link.sck = sck_reg;
   assign link.hostLaneOut = laneOut_reg;
   assign link.hostLaneOe = laneOe_reg;
endmodule

// ### tb/fps_asserts.sv
`timescale 1ns/1ps
module fps_asserts (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic csN,
   input wire logic sck,
   input wire logic [3:0] hostLaneOe,
   input wire logic [3:0] devLaneOe,
   input wire logic [3:0] devLaneOut
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////
   property p_csHighOff;
      csN [*6] |-> devLaneOe == 4'h0;
   endproperty
   a_csHighOff: assert property (p_csHighOff) else $error("flash drives lanes while deselected");
   property p_noClash;
      (devLaneOe & hostLaneOe) == 4'h0;
   endproperty
   a_noClash: assert property (p_noClash) else $error("both ends drive one lane");
   property p_laneSet;
      devLaneOe inside {4'h0, 4'h2, 4'hF};
   endproperty
   a_laneSet: assert property (p_laneSet) else $error("flash lane enables not one or four lanes");
   // output may only move while the link clock is low
   property p_holdHigh;
      sck && $past(sck) && devLaneOe != 4'h0 && $stable(devLaneOe) |-> $stable(devLaneOut & devLaneOe);
   endproperty
   a_holdHigh: assert property (p_holdHigh) else $error("flash output moved while clock high");
   property p_quietStart;
      $fell(csN) |-> (devLaneOe == 4'h0) [*8];
   endproperty
   a_quietStart: assert property (p_quietStart) else $error("flash drives during instruction");
   property p_dropOe;
      $rose(csN) |-> ##[1:5] devLaneOe == 4'h0;
   endproperty
   a_dropOe: assert property (p_dropOe) else $error("flash lanes not released after deselect");
   property p_sckIdle;
      csN |-> !sck;
   endproperty
   a_sckIdle: assert property (p_sckIdle) else $error("link clock high while deselected");
   property p_sckHigh;
      $rose(sck) |-> sck [*8] ##1 !sck;
   endproperty
   a_sckHigh: assert property (p_sckHigh) else $error("link clock high phase wrong");
   c_quadOut: cover property (devLaneOe == 4'hF);
   c_singleOut: cover property (devLaneOe == 4'h2);
   c_abort: cover property ($rose(csN) && devLaneOe != 4'h0);
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
   import fps_pkg::*;
   localparam logic [7:0] MAKER = 8'h5C; // value arbitrary
   localparam logic [15:0] DEVICE = 16'h9E27; // value arbitrary
   localparam logic [63:0] UNIQUE = 64'hC0DEF00D13572468; // value arbitrary
   typedef struct {logic [7:0] c1, c2, c3; logic busy; logic [7:0] op, addr, n; logic [63:0] exp;} fps_row_type;
   logic mclk, reset_n, cfgWrEn, opBusy, paramWrEn, cmdStart, quadPeriph, addrFour, cmdBusy, cmdDone, rxValid;
   logic [1:0] cfgSel;
   logic [7:0] cfgWrData, status1, status2, paramWrAddr, paramWrData, config1, config2, config3;
   logic [7:0] cmdOpcode, byteCount, rxData;
   logic [31:0] cmdAddr;
   logic [3:0] latency;
   logic swapStatus;
   int num_errors = 0;
   int comparisons = 0;
   // parameter memory holds address xor A6; expected bytes are right aligned, first byte highest
   fps_row_type rows[12] = '{
      '{8'h00, 8'h00, 8'h08, 1'b1, OP_STATUS1, 8'h00, 8'h02, 64'h3C3C},
      '{8'h00, 8'h00, 8'h08, 1'b1, OP_STATUS2, 8'h00, 8'h01, 64'hC3},
      '{8'h02, 8'h01, 8'h05, 1'b1, OP_CONFIG1, 8'h00, 8'h01, 64'h02},
      '{8'h02, 8'h01, 8'h05, 1'b0, OP_CONFIG2, 8'h00, 8'h01, 64'h01},
      '{8'h02, 8'h01, 8'h05, 1'b0, OP_CONFIG3, 8'h00, 8'h02, 64'h0505},
      '{8'h00, 8'h00, 8'h08, 1'b0, OP_PARAM, 8'h10, 8'h03, 64'hB6B7B4},
      '{8'h00, 8'h01, 8'h00, 1'b0, OP_PARAM, 8'hFF, 8'h02, 64'h59A6},
      '{8'h00, 8'h00, 8'h08, 1'b0, OP_UNIQUE, 8'h00, 8'h08, UNIQUE},
      '{8'h02, 8'h00, 8'h08, 1'b0, OP_QUAD_IDENT, 8'h00, 8'h03, {40'h0, MAKER, DEVICE}},
      '{8'h00, 8'h08, 8'h08, 1'b0, OP_QUAD_IDENT, 8'h00, 8'h03, {40'h0, MAKER, DEVICE}},
      '{8'h00, 8'h08, 8'h08, 1'b0, OP_STATUS1, 8'h00, 8'h01, 64'h3C},
      '{8'h00, 8'h08, 8'h08, 1'b0, OP_UNIQUE, 8'h00, 8'h02, {48'h0, UNIQUE[63:48]}}};
   fps_link_if link();
   fps_flash_end #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .UNIQUE_NUMBER(UNIQUE)) fps_flash_end_i (
      .mclk(mclk), .reset_n(reset_n), .clkEn(1'b1), .link(link), .cfgWrEn(cfgWrEn), .cfgSel(cfgSel),
      .cfgWrData(cfgWrData), .status1(status1), .status2(status2), .opBusy(opBusy), .paramWrEn(paramWrEn),
      .paramWrAddr(paramWrAddr), .paramWrData(paramWrData), .config1(config1), .config2(config2),
      .config3(config3));
   fps_host_end fps_host_end_i (.mclk(mclk), .reset_n(reset_n), .clkEn(1'b1), .link(link), .cmdStart(cmdStart),
      .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .quadPeriph(quadPeriph), .addrFour(addrFour), .latency(latency),
      .byteCount(byteCount), .cmdBusy(cmdBusy), .cmdDone(cmdDone), .rxData(rxData), .rxValid(rxValid));
   fps_asserts fps_asserts_i (.mclk(mclk), .reset_n(reset_n), .csN(link.csN), .sck(link.sck),
      .hostLaneOe(link.hostLaneOe), .devLaneOe(link.devLaneOe), .devLaneOut(link.devLaneOut));
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // host lane width, address length and latency follow the configuration written just before
   task automatic run(input fps_row_type r);
      int k;
      int w;
      k = 0;
      w = 0;
      cfgSel <= CFG_SEL_1;
      cfgWrData <= r.c1;
      cfgWrEn <= 1'b1;
      opBusy <= r.busy;
      @(posedge mclk);
      cfgSel <= CFG_SEL_2;
      cfgWrData <= r.c2;
      @(posedge mclk);
      cfgSel <= CFG_SEL_3;
      cfgWrData <= r.c3;
      @(posedge mclk);
      cfgWrEn <= 1'b0;
      while (cmdBusy !== 1'b0 && w < 100) begin
         @(posedge mclk);
         w++;
      end
      cmdOpcode <= r.op;
      cmdAddr <= {24'h0, r.addr};
      quadPeriph <= r.c2[CFG2_QPI_BIT];
      addrFour <= r.c2[CFG2_ADDR4_BIT];
      latency <= r.c3[CFG3_LAT_MSB:CFG3_LAT_LSB];
      byteCount <= r.n;
      cmdStart <= 1'b1;
      @(posedge mclk);
      cmdStart <= 1'b0;
      w = 0;
      while (cmdDone !== 1'b1 && w < 4000) begin
         @(posedge mclk);
         w++;
         if (rxValid === 1'b1) begin
            check("rxData", rxData, r.exp[8 * (int'(r.n) - 1 - k) +: 8]);
            if (swapStatus === 1'b1 && k == 0) status1 <= 8'h96;
            k++;
         end
      end
      check("cmdDone", {7'h0, cmdDone}, 8'h01);
      check("byteCount", 8'(k), r.n);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      num_errors++;
      close_out();
   end
   initial begin
      {reset_n, cfgWrEn, opBusy, paramWrEn, cmdStart, quadPeriph, addrFour, swapStatus} = 8'h00;
      {cfgSel, cfgWrData, paramWrAddr, paramWrData, cmdOpcode, byteCount, latency} = 46'h0;
      cmdAddr = 32'h0;
      status1 = 8'h3C;
      status2 = 8'hC3;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      @(posedge mclk);
      check("config1", config1, 8'h00);
      check("config2", config2, 8'h00);
      check("config3", config3, 8'h08);
      paramWrEn <= 1'b1;
      for (int i = 0; i < 256; i++) begin
         paramWrAddr <= 8'(i);
         paramWrData <= 8'(i) ^ 8'hA6;
         @(posedge mclk);
      end
      paramWrEn <= 1'b0;
      foreach (rows[i]) run(rows[i]);
      // refused requests leave the lanes to the pull-ups
      run('{8'h00, 8'h00, 8'h08, 1'b0, OP_QUAD_IDENT, 8'h00, 8'h02, 64'hFFFF});
      run('{8'h02, 8'h00, 8'h08, 1'b1, OP_QUAD_IDENT, 8'h00, 8'h01, 64'hFF});
      // reset in mid-transfer: both ends let go of the link and the configuration returns to defaults
      repeat (16) @(posedge mclk);
      cmdOpcode <= OP_UNIQUE;
      byteCount <= 8'h08;
      cmdStart <= 1'b1;
      @(posedge mclk);
      cmdStart <= 1'b0;
      repeat (700) @(posedge mclk);
      check("devLaneOe", {4'h0, link.devLaneOe}, 8'h02);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      check("config1", config1, CFG1_RESET);
      check("config3", config3, CFG3_RESET);
      check("cmdBusy", {7'h0, cmdBusy}, 8'h00);
      check("csN", {7'h0, link.csN}, 8'h01);
      check("devLaneOe", {4'h0, link.devLaneOe}, 8'h00);
      swapStatus <= 1'b1;
      run('{8'h00, 8'h00, 8'h08, 1'b0, OP_STATUS1, 8'h00, 8'h02, 64'h3C96});
      close_out();
   end
endmodule
